// [verilog/lsr_top.sv]
`timescale 1ns/1ps
module lsr_top
	import lsr_pkg::*;
#(
	parameter int unsigned MS_CYC = MS_CYCLES
) (
	// system clock domain
	input  wire logic        clk_sys_in,
	input  wire logic        rst_b_in,
	input  wire logic        ce_in,
	// link clock domain
	input  wire logic        clk_link_in,
	// serial bus pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_b_out,
	// address strap sense
	input  wire logic        addr_pin_high_in,
	input  wire logic        addr_pin_float_in,
	// converter result
	input  wire logic [15:0] light_raw_in,
	// interrupt pin, open drain
	output logic             int_out,
	output logic             int_oe_b_out
);
	typedef struct packed {
		logic              ce1;
		logic              ce2;
		logic              scl1;
		logic              scl2;
		logic              scl3;
		logic              sda1;
		logic              sda2;
		logic              sda3;
		logic              adh1;
		logic              adh2;
		logic              adf1;
		logic              adf2;
		logic [1:0]        load_cnt;
		logic              loaded;
		logic [6:0]        my_addr;
		lsr_i2c_st_t       st;
		lsr_kind_t         kind;
		logic [3:0]        cnt;
		logic [7:0]        sh;
		logic              rw;
		logic              mack;
		logic [7:0]        ptr;
		logic              oe_b;
		logic              sda_o;
		logic [7:0]        pwr;
		logic [7:0]        srst;
		logic [7:0]        integ;
		logic [7:0]        irqsel;
		logic [7:0]        thr_lo;
		logic [7:0]        thr_hi;
		logic [7:0]        nvm_ptr;
		logic [7:0]        nvm_op;
		logic [9:0][7:0]   nvm;
		logic              clr_tog;
	} lsr_link_t;

	typedef struct packed {
		logic clr_seen;
		logic int_o;
		logic int_oe_b;
	} lsr_sys_t;

	lsr_link_t   rl;
	lsr_link_t   next_rl;
	lsr_sys_t    rs;
	lsr_sys_t    next_rs;
	lsr_cfg_t    cfg_link;
	lsr_cfg_t    cfg_sys;
	logic [15:0] cnt_link;
	logic [15:0] cnt_sys;
	logic        int_act;
	logic        clear_sys;
	logic        irq_en;
	logic        scl_rise;
	logic        scl_fall;
	logic        start;
	logic        stop;
	logic [7:0]  rd_now;
	logic [7:0]  rd_next;

	////////////////////////////////////////////////////////////////////////////
	// register read view

	function automatic logic [7:0] rd_byte(input lsr_link_t s, input logic [15:0] c,
		input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			OFS_POWER:   v = s.pwr;
			OFS_SRST:    v = s.srst;
			OFS_INTEG:   v = s.integ;
			OFS_IRQSEL:  v = s.irqsel;
			OFS_THR_LO:  v = s.thr_lo;
			OFS_THR_HI:  v = s.thr_hi;
			OFS_CNT_LO:  v = c[7:0];
			OFS_CNT_HI:  v = c[15:8];
			OFS_ID_LO:   v = s.nvm[NVM_IDX_ID_LO];
			OFS_ID_HI:   v = s.nvm[NVM_IDX_ID_HI];
			OFS_NVM_PTR: v = s.nvm_ptr;
			OFS_NVM_OP:  v = s.nvm_op;
			default: begin
				if (a >= OFS_NVM_BASE && a <= OFS_NVM_LAST) begin
					v = s.nvm[a[3:0]];
				end
			end
		endcase
		return v;
	endfunction

	assign rd_now = rd_byte(rl, cnt_link, rl.ptr);
	assign rd_next = rd_byte(rl, cnt_link, rl.ptr + 8'h01);

	////////////////////////////////////////////////////////////////////////////
	// bus condition detect, on synchronised pins only

	assign scl_rise = rl.scl2 & ~rl.scl3;
	assign scl_fall = ~rl.scl2 & rl.scl3;
	assign start = rl.scl2 & rl.scl3 & rl.sda3 & ~rl.sda2;
	assign stop = rl.scl2 & rl.scl3 & ~rl.sda3 & rl.sda2;

	////////////////////////////////////////////////////////////////////////////
	// serial slave and register bank, link domain

	always_comb begin
		next_rl = rl;
		next_rl.ce1 = ce_in;
		next_rl.ce2 = rl.ce1;
		next_rl.scl1 = scl_in;
		next_rl.scl2 = rl.scl1;
		next_rl.sda1 = sda_in;
		next_rl.sda2 = rl.sda1;
		next_rl.adh1 = addr_pin_high_in;
		next_rl.adh2 = rl.adh1;
		next_rl.adf1 = addr_pin_float_in;
		next_rl.adf2 = rl.adf1;
		if (rl.ce2) begin
			next_rl.scl3 = rl.scl2;
			next_rl.sda3 = rl.sda2;
			if (!rl.loaded) begin
				// the bus is deaf until the shadow load is done
				next_rl.load_cnt = rl.load_cnt + 2'h1;
				if (rl.load_cnt == LOAD_WAIT) begin
					next_rl.loaded = 1'b1;
					if (rl.adf2) begin
						next_rl.my_addr = ADDR_FLOAT;
					end else if (rl.adh2) begin
						next_rl.my_addr = ADDR_HIGH;
					end else begin
						next_rl.my_addr = ADDR_LOW;
					end
					next_rl.pwr = rl.nvm[NVM_IDX_POWER];
					next_rl.srst = rl.nvm[NVM_IDX_SRST];
					next_rl.integ = rl.nvm[NVM_IDX_INTEG];
					next_rl.irqsel = rl.nvm[NVM_IDX_IRQSEL];
					next_rl.thr_lo = rl.nvm[NVM_IDX_THR_LO];
					next_rl.thr_hi = rl.nvm[NVM_IDX_THR_HI];
				end
			end else if (stop) begin
				next_rl.st = ST_IDLE;
				next_rl.oe_b = 1'b1;
				if (rl.srst == SRST_CMD) begin
					next_rl.clr_tog = ~rl.clr_tog;
					next_rl.srst = SRST_IDLE;
				end
			end else if (start) begin
				next_rl.st = ST_RX;
				next_rl.kind = K_ADDR;
				next_rl.cnt = '0;
				next_rl.oe_b = 1'b1;
			end else begin
				unique case (rl.st)
					ST_IDLE: begin
					end
					ST_RX: begin
						if (scl_rise) begin
							next_rl.sh = {rl.sh[6:0], rl.sda2};
							next_rl.cnt = rl.cnt + 4'h1;
						end else if (scl_fall && rl.cnt == BYTE_BITS) begin
							next_rl.cnt = '0;
							next_rl.oe_b = 1'b0;
							next_rl.st = ST_RX_ACK;
							unique case (rl.kind)
								K_ADDR: begin
									next_rl.rw = rl.sh[0];
									if (rl.sh[7:1] != rl.my_addr) begin
										next_rl.oe_b = 1'b1;
										next_rl.st = ST_IDLE;
									end
								end
								K_REG: begin
									next_rl.ptr = rl.sh;
									next_rl.kind = K_DATA;
								end
								K_DATA: begin
									next_rl.ptr = rl.ptr + 8'h01;
									case (rl.ptr)
										OFS_POWER:   next_rl.pwr = rl.sh;
										OFS_SRST:    next_rl.srst = rl.sh;
										OFS_INTEG:   next_rl.integ = rl.sh;
										OFS_IRQSEL:  next_rl.irqsel = rl.sh;
										OFS_THR_LO:  next_rl.thr_lo = rl.sh;
										OFS_THR_HI:  next_rl.thr_hi = rl.sh;
										OFS_NVM_PTR: next_rl.nvm_ptr = rl.sh;
										OFS_NVM_OP:  next_rl.nvm_op = rl.sh;
										default: begin
											// read-only and unmapped bytes drop the data
											if (rl.ptr >= OFS_NVM_BASE && rl.ptr <= OFS_NVM_LAST) begin
												next_rl.nvm[rl.ptr[3:0]] = rl.sh;
											end
										end
									endcase
								end
							endcase
						end
					end
					ST_RX_ACK: begin
						if (scl_fall) begin
							next_rl.oe_b = 1'b1;
							next_rl.st = ST_RX;
							if (rl.kind == K_ADDR) begin
								next_rl.kind = K_REG;
								if (rl.rw) begin
									next_rl.st = ST_TX;
									next_rl.sh = rd_now;
									next_rl.oe_b = rd_now[7];
									next_rl.cnt = 4'h1;
								end
							end
						end
					end
					ST_TX: begin
						if (scl_fall) begin
							if (rl.cnt == BYTE_BITS) begin
								next_rl.oe_b = 1'b1;
								next_rl.st = ST_TX_ACK;
							end else begin
								next_rl.sh = {rl.sh[6:0], 1'b0};
								next_rl.oe_b = rl.sh[6];
								next_rl.cnt = rl.cnt + 4'h1;
							end
						end
					end
					ST_TX_ACK: begin
						if (scl_rise) begin
							next_rl.mack = ~rl.sda2;
						end else if (scl_fall) begin
							if (rl.mack) begin
								next_rl.ptr = rl.ptr + 8'h01;
								next_rl.sh = rd_next;
								next_rl.oe_b = rd_next[7];
								next_rl.cnt = 4'h1;
								next_rl.st = ST_TX;
							end else begin
								next_rl.st = ST_IDLE;
							end
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_link_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rl <= '0;
			rl.oe_b <= 1'b1;
			rl.nvm <= NVM_DEFAULT;
		end else begin
			rl <= next_rl;
		end
	end

	assign sda_out = rl.sda_o;
	assign sda_oe_b_out = rl.oe_b;

	a_foreign_addr: assert property (
		@(posedge clk_link_in) disable iff (!rst_b_in)
		(rl.ce2 && rl.loaded && rl.st == ST_RX && scl_fall && rl.cnt == BYTE_BITS
			&& rl.kind == K_ADDR && rl.sh[7:1] != rl.my_addr)
		|=> (rl.st == ST_IDLE && sda_oe_b_out)
	) else $error("foreign address was answered");
	a_ptr_advance: assert property (
		@(posedge clk_link_in) disable iff (!rst_b_in)
		(rl.ce2 && rl.loaded && rl.st == ST_RX && scl_fall && rl.cnt == BYTE_BITS
			&& rl.kind == K_DATA)
		|=> (rl.ptr == $past(rl.ptr) + 8'h01 && !sda_oe_b_out)
	) else $error("pointer did not advance after data byte");
	a_ro_untouched: assert property (
		@(posedge clk_link_in) disable iff (!rst_b_in)
		(rl.ce2 && rl.loaded && rl.st == ST_RX && scl_fall && rl.cnt == BYTE_BITS
			&& rl.kind == K_DATA && rl.ptr >= OFS_CNT_LO && rl.ptr <= OFS_ID_HI)
		|=> ($stable(rl.nvm) && $stable(rl.pwr) && $stable(rl.thr_hi))
	) else $error("read-only write changed storage");
	a_sda_on_fall: assert property (
		@(posedge clk_link_in) disable iff (!rst_b_in)
		$changed(sda_oe_b_out) |-> ($past(scl_fall) || $past(stop) || $past(start))
	) else $error("data line moved outside scl low phase");
	a_addr_fixed: assert property (
		@(posedge clk_link_in) disable iff (!rst_b_in)
		rl.loaded |=> $stable(rl.my_addr)
	) else $error("slave address changed after power-up");

	////////////////////////////////////////////////////////////////////////////
	// domain crossings

	assign cfg_link.power_on = (rl.pwr == PWR_ON);
	assign cfg_link.integ = rl.integ;
	assign cfg_link.irqsel = rl.irqsel;
	assign cfg_link.thr_hi = rl.thr_hi;
	assign cfg_link.thr_lo = rl.thr_lo;
	assign cfg_link.trim = rl.nvm[NVM_IDX_TRIM];
	assign cfg_link.clr_tog = rl.clr_tog;

	lsr_xfer #(
		.W ($bits(lsr_cfg_t))
	) u_cfg_xfer (
		.clk_src_in (clk_link_in),
		.clk_dst_in (clk_sys_in),
		.rst_b_in   (rst_b_in),
		.ce_src_in  (rl.ce2),
		.ce_dst_in  (ce_in),
		.data_in    (cfg_link),
		.data_out   (cfg_sys)
	);

	lsr_xfer #(
		.W (16)
	) u_cnt_xfer (
		.clk_src_in (clk_sys_in),
		.clk_dst_in (clk_link_in),
		.rst_b_in   (rst_b_in),
		.ce_src_in  (ce_in),
		.ce_dst_in  (rl.ce2),
		.data_in    (cnt_sys),
		.data_out   (cnt_link)
	);

	////////////////////////////////////////////////////////////////////////////
	// measurement and interrupt pin, system domain

	assign clear_sys = cfg_sys.clr_tog != rs.clr_seen;
	assign irq_en = (cfg_sys.irqsel == IRQ_L2H) || (cfg_sys.irqsel == IRQ_H2L);

	lsr_meas #(
		.MS_CYC (MS_CYC)
	) u_meas (
		.clk_sys_in   (clk_sys_in),
		.rst_b_in     (rst_b_in),
		.ce_in        (ce_in),
		.power_on_in  (cfg_sys.power_on),
		.integ_in     (cfg_sys.integ),
		.trim_in      (cfg_sys.trim),
		.thresh_in    ({cfg_sys.thr_hi, cfg_sys.thr_lo}),
		.irq_en_in    (irq_en),
		.clear_in     (clear_sys),
		.light_raw_in (light_raw_in),
		.count_out    (cnt_sys),
		.int_act_out  (int_act)
	);

	always_comb begin
		next_rs = rs;
		next_rs.clr_seen = cfg_sys.clr_tog;
		next_rs.int_o = 1'b0;
		// open drain: rising mode can only show activity by releasing the pin
		unique case (cfg_sys.irqsel)
			IRQ_L2H: next_rs.int_oe_b = int_act;
			IRQ_H2L: next_rs.int_oe_b = ~int_act;
			default: next_rs.int_oe_b = 1'b1;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rs <= '0;
			rs.int_oe_b <= 1'b1;
		end else if (ce_in) begin
			rs <= next_rs;
		end
	end

	assign int_out = rs.int_o;
	assign int_oe_b_out = rs.int_oe_b;

	a_irq_disabled: assert property (
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(ce_in && cfg_sys.irqsel == IRQ_OFF) |=> int_oe_b_out
	) else $error("disabled interrupt pin not released");
endmodule

// [common/lsr_pkg.sv]
// What this block does
// - light measurement kept as unsigned 16-bit count
// - trim code from nvm 0x16 applies immediately
// - trim 0xff smallest span, 0x00 largest
// - interrupt once count rises above threshold
// - powered on: measure continuously, latest count readable
// - power-down stops measuring, interrupt inactive, registers kept
// - bytes are eight bits, msb first, then ack
// - single and block register reads and writes
// - address 0x29 high, 0x39 floating, 0x49 low
// - address pin sampled only at power-up
// - write: address, pointer, data; pointer advances per byte
// - writes to read-only registers only move pointer
// - read: ack address, send pointed byte, then next
// - integration codes select 400 to 2 ms periods
// - soft reset command 0x30 clears light count
// - threshold bytes at 0x04/0x05, high defaults 0x08
// - count bytes at 0x06/0x07, read-only, reset zero
// - nvm pointer at 0x0a, nvm control at 0x0b
// - power-up loads registers 0x00 to 0x05 from nvm shadow
// - 0x10 powers up, 0x00 down, starts down
// - interrupt held while count above threshold, if enabled
// - polarity 0x01 rising, 0x02 falling, 0x03 released
package lsr_pkg;
	// 20 MHz system clock
	localparam int unsigned CLK_HZ    = 32'h0131_2d00;
	localparam int unsigned MS_PER_S  = 32'h0000_03e8;
	localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;

	localparam logic [7:0] OFS_POWER    = 8'h00;
	localparam logic [7:0] OFS_SRST     = 8'h01;
	localparam logic [7:0] OFS_INTEG    = 8'h02;
	localparam logic [7:0] OFS_IRQSEL   = 8'h03;
	localparam logic [7:0] OFS_THR_LO   = 8'h04;
	localparam logic [7:0] OFS_THR_HI   = 8'h05;
	localparam logic [7:0] OFS_CNT_LO   = 8'h06;
	localparam logic [7:0] OFS_CNT_HI   = 8'h07;
	localparam logic [7:0] OFS_ID_LO    = 8'h08;
	localparam logic [7:0] OFS_ID_HI    = 8'h09;
	localparam logic [7:0] OFS_NVM_PTR  = 8'h0a;
	localparam logic [7:0] OFS_NVM_OP   = 8'h0b;
	localparam logic [7:0] OFS_NVM_BASE = 8'h10;
	localparam logic [7:0] OFS_NVM_LAST = 8'h19;

	// nvm shadow slots, relative to the window base
	localparam logic [3:0] NVM_IDX_POWER  = 4'h0;
	localparam logic [3:0] NVM_IDX_SRST   = 4'h1;
	localparam logic [3:0] NVM_IDX_INTEG  = 4'h2;
	localparam logic [3:0] NVM_IDX_IRQSEL = 4'h3;
	localparam logic [3:0] NVM_IDX_THR_LO = 4'h4;
	localparam logic [3:0] NVM_IDX_THR_HI = 4'h5;
	localparam logic [3:0] NVM_IDX_TRIM   = 4'h6;
	localparam logic [3:0] NVM_IDX_ID_LO  = 4'h8;
	localparam logic [3:0] NVM_IDX_ID_HI  = 4'h9;
	// trim and unused slot defaults are arbitrary
	localparam logic [9:0][7:0] NVM_DEFAULT = {8'h00, 8'h00, 8'h00, 8'h00, 8'h08,
		8'h00, 8'h03, 8'h91, 8'h00, 8'h00};

	localparam logic [7:0] PWR_ON   = 8'h10;
	localparam logic [7:0] SRST_CMD = 8'h30;
	localparam logic [7:0] SRST_IDLE = 8'h00;
	localparam logic [7:0] IRQ_L2H  = 8'h01;
	localparam logic [7:0] IRQ_H2L  = 8'h02;
	localparam logic [7:0] IRQ_OFF  = 8'h03;

	localparam logic [7:0] INTEG_400 = 8'h90;
	localparam logic [7:0] INTEG_200 = 8'h91;
	localparam logic [7:0] INTEG_100 = 8'ha0;
	localparam logic [7:0] INTEG_50  = 8'ha1;
	localparam logic [7:0] INTEG_20  = 8'hb0;
	localparam logic [7:0] INTEG_2   = 8'hb1;
	localparam logic [8:0] PER_400_MS = 9'h190;
	localparam logic [8:0] PER_200_MS = 9'h0c8;
	localparam logic [8:0] PER_100_MS = 9'h064;
	localparam logic [8:0] PER_50_MS  = 9'h032;
	localparam logic [8:0] PER_20_MS  = 9'h014;
	localparam logic [8:0] PER_2_MS   = 9'h002;

	localparam logic [6:0] ADDR_HIGH  = 7'h29;
	localparam logic [6:0] ADDR_FLOAT = 7'h39;
	localparam logic [6:0] ADDR_LOW   = 7'h49;

	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [1:0] LOAD_WAIT = 2'h3;

	// count = raw * (825 - 2*trim) / 520, the divide done as *126 >> 16
	localparam logic [9:0] TRIM_SPAN_MAX = 10'h339;
	localparam logic [6:0] SCALE_MUL     = 7'h7e;
	localparam int unsigned SCALE_SHIFT  = 32'h0000_0010;

	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} lsr_i2c_st_t;
	typedef enum logic [1:0] {K_ADDR, K_REG, K_DATA} lsr_kind_t;

	typedef struct packed {
		logic       power_on;
		logic [7:0] integ;
		logic [7:0] irqsel;
		logic [7:0] thr_hi;
		logic [7:0] thr_lo;
		logic [7:0] trim;
		logic       clr_tog;
	} lsr_cfg_t;
endpackage

// [verilog/lsr_xfer.sv]
`timescale 1ns/1ps
module lsr_xfer
	import lsr_pkg::*;
#(
	parameter int unsigned W = 8
) (
	// clocks and reset
	input  wire logic         clk_src_in,
	input  wire logic         clk_dst_in,
	input  wire logic         rst_b_in,
	input  wire logic         ce_src_in,
	input  wire logic         ce_dst_in,
	// word
	input  wire logic [W-1:0] data_in,
	output logic      [W-1:0] data_out
);
	typedef struct packed {
		logic         req;
		logic         ack1;
		logic         ack2;
		logic [W-1:0] hold;
	} lsr_xsrc_t;
	typedef struct packed {
		logic         req1;
		logic         req2;
		logic         req3;
		logic         ack;
		logic [W-1:0] data;
	} lsr_xdst_t;

	lsr_xsrc_t s;
	lsr_xsrc_t next_s;
	lsr_xdst_t d;
	lsr_xdst_t next_d;

	// toggle handshake: hold stays frozen from request toggle until ack returns
	always_comb begin
		next_s = s;
		next_s.ack1 = d.ack;
		next_s.ack2 = s.ack1;
		if (ce_src_in && s.ack2 == s.req) begin
			next_s.hold = data_in;
			next_s.req = ~s.req;
		end
	end

	always_comb begin
		next_d = d;
		next_d.req1 = s.req;
		next_d.req2 = d.req1;
		if (ce_dst_in) begin
			next_d.req3 = d.req2;
			if (d.req2 != d.req3) begin
				next_d.data = s.hold;
				next_d.ack = d.req2;
			end
		end
	end

	always_ff @(posedge clk_src_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	always_ff @(posedge clk_dst_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			d <= '0;
		end else begin
			d <= next_d;
		end
	end

	assign data_out = d.data;
endmodule

// [verilog/lsr_meas.sv]
`timescale 1ns/1ps
module lsr_meas
	import lsr_pkg::*;
#(
	parameter int unsigned MS_CYC = MS_CYCLES
) (
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_b_in,
	input  wire logic        ce_in,
	// configuration
	input  wire logic        power_on_in,
	input  wire logic [7:0]  integ_in,
	input  wire logic [7:0]  trim_in,
	input  wire logic [15:0] thresh_in,
	input  wire logic        irq_en_in,
	input  wire logic        clear_in,
	// converter result and outcome
	input  wire logic [15:0] light_raw_in,
	output logic      [15:0] count_out,
	output logic             int_act_out
);
	typedef struct packed {
		logic [15:0] pre;
		logic [8:0]  ms;
		logic [15:0] raw;
		logic [15:0] count;
		logic        int_act;
	} lsr_meas_t;

	lsr_meas_t r;
	lsr_meas_t next_r;
	logic [8:0]  per;
	logic [9:0]  span;
	logic [32:0] prod;

	always_comb begin
		unique case (integ_in)
			INTEG_400: per = PER_400_MS;
			INTEG_100: per = PER_100_MS;
			INTEG_50:  per = PER_50_MS;
			INTEG_20:  per = PER_20_MS;
			INTEG_2:   per = PER_2_MS;
			default:   per = PER_200_MS;
		endcase
	end

	// scaled from the held sample every cycle, so a trim change shows at once
	assign span = TRIM_SPAN_MAX - {1'b0, trim_in, 1'b0};
	assign prod = 33'(r.raw) * 33'(span) * 33'(SCALE_MUL);

	always_comb begin
		next_r = r;
		next_r.count = prod[32:SCALE_SHIFT] > 17'h0ffff ? 16'hffff : prod[31:SCALE_SHIFT];
		next_r.int_act = power_on_in && irq_en_in && (r.count > thresh_in);
		if (power_on_in) begin
			next_r.pre = r.pre + 16'h0001;
			if (r.pre >= 16'(MS_CYC - 1)) begin
				next_r.pre = '0;
				next_r.ms = r.ms + 9'h001;
				if (r.ms >= per - 9'h001) begin
					next_r.ms = '0;
					next_r.raw = light_raw_in;
				end
			end
		end else begin
			next_r.pre = '0;
			next_r.ms = '0;
		end
		if (clear_in) begin
			next_r.raw = '0;
			next_r.count = '0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			r <= '0;
		end else if (ce_in) begin
			r <= next_r;
		end
	end

	assign count_out = r.count;
	assign int_act_out = r.int_act;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);

	a_clear_zeroes_count: assert property (
		(ce_in && clear_in) |=> (count_out == 16'h0000)
	) else $error("count not cleared by soft reset");
	a_powerdown_no_irq: assert property (
		(ce_in && !power_on_in) |=> !int_act_out
	) else $error("interrupt active while powered down");
	a_above_thresh_irq: assert property (
		(ce_in && power_on_in && irq_en_in && r.count > thresh_in) |=> int_act_out
	) else $error("count above threshold without interrupt");
	// a shorter code may arrive mid-period, so check the wrap, not the running count
	a_period_bound: assert property (
		(ce_in && power_on_in && !clear_in && r.pre >= 16'(MS_CYC - 1) && r.ms >= per - 9'h001)
		|=> (r.ms == 9'h000 && r.raw == $past(light_raw_in))
	) else $error("integration period end missed");
	a_trim_min_span: assert property (
		(ce_in && !clear_in && r.raw == 16'h0208 && trim_in == 8'hff)
		|=> (count_out >= 16'h013a && count_out <= 16'h013c)
	) else $error("trim 0xff span wrong");
endmodule

// [bench/lsr_master.sv]
`timescale 1ns/1ps
module lsr_master (
	// bus side
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_out
);
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// scl low 5 cycles, high 4: above the slave's oversampling minimum
	task automatic bit_io(input logic b, output logic r);
		scl_out <= 1'b0;
		hold(2);
		sda_out <= b;
		hold(3);
		scl_out <= 1'b1;
		hold(4);
		r = sda_in;
	endtask

	task automatic start;
		sda_out <= 1'b1;
		hold(4);
		sda_out <= 1'b0;
		hold(4);
	endtask

	task automatic stop;
		scl_out <= 1'b0;
		hold(3);
		sda_out <= 1'b0;
		hold(3);
		scl_out <= 1'b1;
		hold(4);
		sda_out <= 1'b1;
		hold(6);
	endtask

	// msb first, then one ack bit driven by a
	task automatic byte_io(input logic [7:0] d, input logic a,
		output logic [7:0] q, output logic ak);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(a, ak);
	endtask
endmodule

// [bench/light_sensor_i2c_regs_bench.sv]
`timescale 1ns/1ps
module light_sensor_i2c_regs_bench
	import lsr_pkg::*;
;
	logic        clk_sys;
	logic        clk_link;
	logic        rst_b;
	logic        scl;
	logic        m_sda;
	wire         sda;
	logic        s_sda;
	logic        s_oe_b;
	logic        irq_oe_b;
	logic        irq_o;
	wire         irq_pin;
	logic        addr_float;
	logic [15:0] light_raw;
	logic [7:0]  rb [6];
	int          n_errors;
	int          checked;

	// pulled-up wire: low if either side pulls
	assign sda = m_sda & (s_oe_b | s_sda);
	// interrupt pin with its pull-up
	assign irq_pin = irq_oe_b | irq_o;

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		clk_link = 1'b0;
		#7;
		forever #16 clk_link = ~clk_link;
	end

	lsr_top #(.MS_CYC(20)) i_lsr_top (
		.clk_sys_in(clk_sys), .rst_b_in(rst_b), .ce_in(1'b1), .clk_link_in(clk_link),
		.scl_in(scl), .sda_in(sda), .sda_out(s_sda), .sda_oe_b_out(s_oe_b),
		.addr_pin_high_in(1'b1), .addr_pin_float_in(addr_float), .light_raw_in(light_raw),
		.int_out(irq_o), .int_oe_b_out(irq_oe_b));
	lsr_master i_lsr_master (.clk_in(clk_sys), .sda_in(sda), .scl_out(scl), .sda_out(m_sda));

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		if (n_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] p, input int n, input logic [47:0] d);
		logic [7:0] q;
		logic       ak;
		i_lsr_master.start();
		i_lsr_master.byte_io({ADDR_HIGH, 1'b0}, 1'b1, q, ak);
		chk8({7'h00, ak}, 8'h00);
		i_lsr_master.byte_io(p, 1'b1, q, ak);
		chk8({7'h00, ak}, 8'h00);
		for (int i = 0; i < n; i++) begin
			i_lsr_master.byte_io(d[8*i+:8], 1'b1, q, ak);
			chk8({7'h00, ak}, 8'h00);
		end
		i_lsr_master.stop();
	endtask

	// last byte nacked, then stop
	task automatic rd(input logic [7:0] p, input int n);
		logic [7:0] q;
		logic       ak;
		wr(p, 0, 48'h0);
		i_lsr_master.start();
		i_lsr_master.byte_io({ADDR_HIGH, 1'b1}, 1'b1, q, ak);
		chk8({7'h00, ak}, 8'h00);
		for (int i = 0; i < n; i++)
			i_lsr_master.byte_io(8'hff, i == n - 1, rb[i], ak);
		i_lsr_master.stop();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_defaults;
		logic [47:0] e;
		e = {8'h08, 8'h00, IRQ_OFF, INTEG_200, SRST_IDLE, 8'h00};
		rd(OFS_POWER, 6);
		for (int i = 0; i < 6; i++)
			chk8(rb[i], e[8*i+:8]);
	endtask

	task automatic t_foreign;
		logic [7:0] q;
		logic       ak;
		i_lsr_master.start();
		i_lsr_master.byte_io({ADDR_FLOAT, 1'b0}, 1'b1, q, ak);
		chk8({7'h00, ak}, 8'h01);
		i_lsr_master.stop();
		wr(OFS_CNT_LO, 1, 48'haa);
		rd(OFS_CNT_LO, 1);
		chk8(rb[0], 8'h00);
	endtask

	task automatic t_measure;
		int c;
		c = (1000 * 825 * 126) >> 16;
		wr(OFS_POWER, 6, {8'h06, 8'h00, IRQ_H2L, INTEG_2, SRST_IDLE, PWR_ON});
		idle(300);
		rd(OFS_CNT_LO, 2);
		chk8(rb[0], c[7:0]);
		chk8(rb[1], c[15:8]);
		chk8({7'h00, irq_pin}, 8'h00);
	endtask

	task automatic t_thresh;
		wr(OFS_THR_LO, 2, 48'h0640);
		idle(30);
		chk8({7'h00, irq_pin}, 8'h01);
		wr(OFS_THR_LO, 1, 48'h00);
		idle(30);
		chk8({7'h00, irq_pin}, 8'h00);
		wr(OFS_IRQSEL, 1, {40'h0, IRQ_L2H});
		idle(30);
		chk8({7'h00, irq_pin}, 8'h01);
	endtask

	// rising polarity: an inactive pin is pulled low
	task automatic t_down;
		wr(OFS_POWER, 1, 48'h00);
		idle(30);
		chk8({7'h00, irq_pin}, 8'h00);
		rd(OFS_CNT_LO, 2);
		chk8(rb[0], 8'h32);
		chk8(rb[1], 8'h06);
		wr(OFS_SRST, 1, {40'h0, SRST_CMD});
		idle(30);
		rd(OFS_CNT_LO, 2);
		chk8(rb[0] | rb[1], 8'h00);
		rd(OFS_SRST, 1);
		chk8(rb[0], SRST_IDLE);
	endtask

	// reference level 520; strap moved after power-up must not move the address
	task automatic t_trim;
		int c;
		light_raw <= 16'h0208;
		addr_float <= 1'b1;
		wr(OFS_NVM_BASE + 8'(NVM_IDX_TRIM), 1, 48'hff);
		wr(OFS_POWER, 1, {40'h0, PWR_ON});
		idle(300);
		c = (520 * 315 * 126) >> 16;
		rd(OFS_CNT_LO, 2);
		chk8(rb[0], c[7:0]);
		chk8(rb[1], c[15:8]);
		chk8({7'h00, irq_pin}, 8'h00);
		wr(OFS_NVM_BASE + 8'(NVM_IDX_TRIM), 1, 48'h00);
		idle(30);
		c = (520 * 825 * 126) >> 16;
		rd(OFS_CNT_LO, 2);
		chk8(rb[0], c[7:0]);
		chk8(rb[1], c[15:8]);
		wr(OFS_NVM_PTR, 2, 48'h01_16);
		rd(OFS_NVM_PTR, 2);
		chk8(rb[0], 8'h16);
		chk8(rb[1], 8'h01);
	endtask

	initial begin
		n_errors = 0;
		checked = 0;
		rst_b = 1'b0;
		light_raw = 16'h03e8;
		addr_float = 1'b0;
		idle(8);
		rst_b <= 1'b1;
		idle(20);
		t_defaults();
		t_foreign();
		t_measure();
		t_thresh();
		t_down();
		t_trim();
		end_of_test();
	end

	initial begin
		idle(60000);
		n_errors++;
		end_of_test();
	end
endmodule
